// ===== logic/pdw_pkg.sv
// Package with register map, timing constants and carriers for power control.
package pdw_pkg;

    // Register offsets.
    localparam logic [7:0] OFS_INT_STATUS   = 8'h02;
    localparam logic [7:0] OFS_RX_WAKE_SRC  = 8'h45;
    localparam logic [7:0] OFS_RX_SLEEP_LO  = 8'h46;
    localparam logic [7:0] OFS_RX_SLEEP_HI  = 8'h47;
    localparam logic [7:0] OFS_RX_WAKE_CNT  = 8'h48;
    localparam logic [7:0] OFS_RX_XFER      = 8'h4b;
    localparam logic [7:0] OFS_RX_WAKE_EXT  = 8'h4c;
    localparam logic [7:0] OFS_TX_WAKE_EXT  = 8'h4d;
    localparam logic [7:0] OFS_TX_MODE      = 8'h54;
    localparam logic [7:0] OFS_RX_MODE      = 8'h55;
    localparam logic [7:0] OFS_TX_SLEEP_LO  = 8'h57;
    localparam logic [7:0] OFS_TX_SLEEP_HI  = 8'h58;
    localparam logic [7:0] OFS_TX_WAKE_CNT  = 8'h59;

    // Reset values.
    localparam logic [7:0] RST_RX_WAKE_SRC  = 8'h28;
    localparam logic [7:0] RST_TIMER        = 8'h00;
    localparam logic [7:0] RST_TX_MODE      = 8'h40;
    localparam logic [7:0] RST_RX_MODE      = 8'h80;

    // Field positions.
    localparam int BIT_TX_POWER      = 6;
    localparam int BIT_TX_PIN_WAKE   = 5;
    localparam int BIT_RX_POWER      = 7;
    localparam int BIT_SLEEP_WAKE    = 4;
    localparam int BIT_WAKE_FLAG     = 1;
    localparam logic [7:0] WAKE_SRC_MASK = 8'h3f;

    // Transfer register codes.
    localparam logic [7:0] XFER_IDLE = 8'h00;
    localparam logic [7:0] XFER_BUSY = 8'h01;

    // Timing: times in their own units, cycle counts derived from the clock.
    localparam int CLK_PERIOD_NS  = 100;
    localparam int TICK_TIME_US   = 10000;
    localparam int FILTER_TIME_US = 1000;
    localparam int TICK_CYCLES    = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int FILTER_CYCLES  =
        (FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W         = 17;
    localparam int FILTER_W       = 17;
    localparam int NUM_PINS       = 5;

    typedef struct packed {
        logic [15:0] sleep_count;
        logic [7:0]  wake_count;
        logic [7:0]  extension;
        logic        sleep_en;
    } pdw_timer_cfg_t;

    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_SLEEP  = 3'b010,
        ST_WAKE   = 3'b100
    } pdw_state_t;

endpackage

// ===== logic/pdw_side_timer.sv
// Sleep and wake timer set with power state machine for one side of a pair.
`timescale 1ns/100ps
module pdw_side_timer (
    input  wire logic                    ref_clk,
    input  wire logic                    reset_n,
    input  wire logic                    tick,
    input  wire logic                    power_bit,
    input  wire logic                    pin_wake,
    input  wire logic                    link_up,
    input  wire pdw_pkg::pdw_timer_cfg_t cfg,
    output logic                         powered_down,
    output logic                         wake_pulse
);
    import pdw_pkg::*;

    pdw_state_t  state_reg;
    pdw_state_t  state_next;
    logic [7:0]  win_reg;
    logic [7:0]  ext_reg;
    logic [15:0] sleep_reg;

    wire wake_set   = cfg.wake_count != 8'h00;
    wire win_last   = tick && win_reg == 8'h01 && ext_reg == 8'h00;
    wire sleep_done = tick && cfg.sleep_en && sleep_reg == 16'h0001;
    wire relinked   = link_up && power_bit;
    wire entering   = state_next != state_reg;
    // A cleared window counter refills in the active state, so automatic power
    // down is armed even when no link was ever seen.
    wire reload     = entering || (state_reg == ST_ACTIVE
                      && (link_up || win_reg == 8'h00));
    wire counting   = tick && state_reg != ST_SLEEP && win_reg != 8'h00;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_ACTIVE: begin
                // A zero wake time blocks both ways into power down.
                if (wake_set && (!power_bit || (!link_up && win_last))) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (sleep_done || pin_wake) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // Staying up needs both a link and the power bit back on.
                if (relinked) begin
                    state_next = ST_ACTIVE;
                end else if (win_last && wake_set) begin
                    state_next = ST_SLEEP;
                end
            end
            default: state_next = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg    <= ST_ACTIVE;
            powered_down <= 1'b0;
            wake_pulse   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            powered_down <= state_next == ST_SLEEP;
            wake_pulse   <= state_reg == ST_SLEEP && state_next == ST_WAKE;
        end
    end

    // Window length is wake count times (extension plus one) ticks.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            win_reg   <= 8'h00;
            ext_reg   <= 8'h00;
            sleep_reg <= 16'h0000;
        end else if (reload) begin
            win_reg   <= cfg.wake_count;
            ext_reg   <= cfg.extension;
            sleep_reg <= cfg.sleep_count;
        end else begin
            if (counting && win_reg == 8'h01 && ext_reg != 8'h00) begin
                win_reg <= cfg.wake_count;
                ext_reg <= ext_reg - 8'h01;
            end else if (counting && win_reg != 8'h01) begin
                win_reg <= win_reg - 8'h01;
            end
            if (tick && state_reg == ST_SLEEP && sleep_reg > 16'h0001) begin
                sleep_reg <= sleep_reg - 16'h0001;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence in_wake_no_link;
        state_reg == ST_WAKE && !relinked;
    endsequence

    sequence window_ends;
        win_last && wake_set;
    endsequence

    wake_needed_a: assert property (
        $rose(powered_down) |-> $past(cfg.wake_count) != 8'h00)
        else $error("power down entered with zero wake time");
    forced_entry_a: assert property (
        state_reg == ST_ACTIVE && !power_bit && wake_set |=> powered_down)
        else $error("forced power down not taken");
    wake_exit_a: assert property (
        wake_pulse |-> $fell(powered_down))
        else $error("wake pulse without leaving power down");
    timeout_back_a: assert property (
        (in_wake_no_link and window_ends) |=> powered_down [*2])
        else $error("wake window expired but device stayed up");
    relink_hold_a: assert property (
        state_reg == ST_WAKE && relinked |=> state_reg == ST_ACTIVE)
        else $error("relink did not end the wake window");
    sleep_gate_a: assert property (
        state_reg == ST_SLEEP && !cfg.sleep_en && !pin_wake |=> powered_down)
        else $error("sleep timer woke device while disabled");
    zero_wake_a: assert property (
        state_reg == ST_ACTIVE && power_bit && !wake_set |=> !powered_down)
        else $error("automatic power down with zero wake time");

endmodule

// ===== logic/pdw_top.sv
// Power-down and wake-up controller holding both timer sets of a pair.
`timescale 1ns/100ps
module pdw_top #(
    parameter int TICK_LEN   = pdw_pkg::TICK_CYCLES,
    parameter int FILTER_LEN = pdw_pkg::FILTER_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       direct_input_bit1,
    input  wire logic [3:0] general_inputs,
    input  wire logic       tx_link_up,
    input  wire logic       rx_link_up,
    input  wire logic       rx_settings_arrived,
    output logic            rx_xfer_req,
    output logic            tx_powered_down,
    output logic            rx_powered_down
);
    import pdw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [7:0]  tx_mode_reg;
    logic [7:0]  rx_mode_reg;
    logic [7:0]  rx_wake_src_reg;
    logic [15:0] rx_sleep_reg;
    logic [7:0]  rx_wake_cnt_reg;
    logic [7:0]  rx_wake_ext_reg;
    logic [15:0] tx_sleep_reg;
    logic [7:0]  tx_wake_cnt_reg;
    logic [7:0]  tx_wake_ext_reg;
    logic [7:0]  rx_xfer_reg;
    logic        rx_power_applied_reg;
    logic        wake_flag_reg;
    logic [7:0]  rd_mux;

    wire wr_int  = reg_wr && reg_addr == OFS_INT_STATUS;
    wire wr_xfer = reg_wr && reg_addr == OFS_RX_XFER;
    wire xfer_go = wr_xfer && reg_wdata == XFER_BUSY
                   && rx_xfer_reg == XFER_IDLE;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_mode_reg     <= RST_TX_MODE;
            rx_mode_reg     <= RST_RX_MODE;
            rx_wake_src_reg <= RST_RX_WAKE_SRC;
            rx_sleep_reg    <= {RST_TIMER, RST_TIMER};
            rx_wake_cnt_reg <= RST_TIMER;
            rx_wake_ext_reg <= RST_TIMER;
            tx_sleep_reg    <= {RST_TIMER, RST_TIMER};
            tx_wake_cnt_reg <= RST_TIMER;
            tx_wake_ext_reg <= RST_TIMER;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_TX_MODE:     tx_mode_reg           <= reg_wdata;
                OFS_RX_MODE:     rx_mode_reg           <= reg_wdata;
                OFS_RX_WAKE_SRC: rx_wake_src_reg       <=
                                     reg_wdata & WAKE_SRC_MASK;
                OFS_RX_SLEEP_LO: rx_sleep_reg[7:0]     <= reg_wdata;
                OFS_RX_SLEEP_HI: rx_sleep_reg[15:8]    <= reg_wdata;
                OFS_RX_WAKE_CNT: rx_wake_cnt_reg       <= reg_wdata;
                OFS_RX_WAKE_EXT: rx_wake_ext_reg       <= reg_wdata;
                OFS_TX_SLEEP_LO: tx_sleep_reg[7:0]     <= reg_wdata;
                OFS_TX_SLEEP_HI: tx_sleep_reg[15:8]    <= reg_wdata;
                OFS_TX_WAKE_CNT: tx_wake_cnt_reg       <= reg_wdata;
                OFS_TX_WAKE_EXT: tx_wake_ext_reg       <= reg_wdata;
                default:         tx_mode_reg           <= tx_mode_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver settings transfer. The receiver power bit only takes effect
    // once the settings have reached the far side, so a controller that
    // forgets the transfer leaves the receiver running.

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_xfer_reg          <= XFER_IDLE;
            rx_xfer_req          <= 1'b0;
            rx_power_applied_reg <= RST_RX_MODE[BIT_RX_POWER];
        end else begin
            rx_xfer_req <= xfer_go;
            if (xfer_go) begin
                rx_xfer_reg <= XFER_BUSY;
            end else if (rx_xfer_reg == XFER_BUSY && rx_settings_arrived) begin
                rx_xfer_reg          <= XFER_IDLE;
                rx_power_applied_reg <= rx_mode_reg[BIT_RX_POWER];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick divider: one enable pulse every tick period.

    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;
    wire tick_wrap = tick_cnt_reg == TICK_W'(TICK_LEN - 1);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_wrap ? '0 : tick_cnt_reg + TICK_W'(1);
            tick_reg     <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin change filter. A change must persist for the full filter time
    // before it counts, so glitches and bounce never wake the device.

    wire  [NUM_PINS-1:0] pin_in = {general_inputs, direct_input_bit1};
    logic [NUM_PINS-1:0] pin_chg;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_filt
            logic                stable_reg;
            logic                chg_reg;
            logic [FILTER_W-1:0] cnt_reg;
            wire differs = pin_in[gi] != stable_reg;
            wire settled = cnt_reg == FILTER_W'(FILTER_LEN - 1);
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    stable_reg <= 1'b0;
                    chg_reg    <= 1'b0;
                    cnt_reg    <= '0;
                end else begin
                    chg_reg <= differs && settled;
                    if (!differs || settled) begin
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + FILTER_W'(1);
                    end
                    if (differs && settled) begin
                        stable_reg <= pin_in[gi];
                    end
                end
            end
            assign pin_chg[gi] = chg_reg;
        end
    endgenerate

    // The first filter pass after reset may report the pin's level as a
    // change; both sides are awake then, so it has no effect.
    wire tx_pin_wake = pin_chg[0] && tx_mode_reg[BIT_TX_PIN_WAKE];
    wire rx_pin_wake = |(pin_chg[NUM_PINS-1:1] & rx_wake_src_reg[3:0])
                       && !rx_wake_src_reg[BIT_SLEEP_WAKE];

    ////////////////////////////////////////////////////////////////////////
    // The two independent timer sets.

    pdw_timer_cfg_t tx_cfg;
    pdw_timer_cfg_t rx_cfg;
    logic           tx_wake;
    logic           rx_wake;

    assign tx_cfg = '{sleep_count: tx_sleep_reg, wake_count: tx_wake_cnt_reg,
                      extension: tx_wake_ext_reg, sleep_en: 1'b1};
    assign rx_cfg = '{sleep_count: rx_sleep_reg, wake_count: rx_wake_cnt_reg,
                      extension: rx_wake_ext_reg,
                      sleep_en: rx_wake_src_reg[BIT_SLEEP_WAKE]};

    pdw_side_timer u_tx_timer (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .tick         (tick_reg),
        .power_bit    (tx_mode_reg[BIT_TX_POWER]),
        .pin_wake     (tx_pin_wake),
        .link_up      (tx_link_up),
        .cfg          (tx_cfg),
        .powered_down (tx_powered_down),
        .wake_pulse   (tx_wake)
    );

    pdw_side_timer u_rx_timer (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .tick         (tick_reg),
        .power_bit    (rx_power_applied_reg),
        .pin_wake     (rx_pin_wake),
        .link_up      (rx_link_up),
        .cfg          (rx_cfg),
        .powered_down (rx_powered_down),
        .wake_pulse   (rx_wake)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wake status flag and read path. A wake in the cycle of a clear wins.

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wake_flag_reg <= 1'b0;
        end else if (tx_wake || rx_wake) begin
            wake_flag_reg <= 1'b1;
        end else if (wr_int && reg_wdata[BIT_WAKE_FLAG]) begin
            wake_flag_reg <= 1'b0;
        end
    end

    always_comb begin
        case (reg_addr)
            OFS_INT_STATUS:  rd_mux = {6'h00, wake_flag_reg, 1'b0};
            OFS_TX_MODE:     rd_mux = tx_mode_reg;
            OFS_RX_MODE:     rd_mux = rx_mode_reg;
            OFS_RX_WAKE_SRC: rd_mux = rx_wake_src_reg;
            OFS_RX_SLEEP_LO: rd_mux = rx_sleep_reg[7:0];
            OFS_RX_SLEEP_HI: rd_mux = rx_sleep_reg[15:8];
            OFS_RX_WAKE_CNT: rd_mux = rx_wake_cnt_reg;
            OFS_RX_WAKE_EXT: rd_mux = rx_wake_ext_reg;
            OFS_RX_XFER:     rd_mux = rx_xfer_reg;
            OFS_TX_SLEEP_LO: rd_mux = tx_sleep_reg[7:0];
            OFS_TX_SLEEP_HI: rd_mux = tx_sleep_reg[15:8];
            OFS_TX_WAKE_CNT: rd_mux = tx_wake_cnt_reg;
            OFS_TX_WAKE_EXT: rd_mux = tx_wake_ext_reg;
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    xfer_done_a: assert property (
        rx_xfer_reg == XFER_BUSY && rx_settings_arrived && !xfer_go
        |=> rx_xfer_reg == XFER_IDLE
            && rx_power_applied_reg == $past(rx_mode_reg[BIT_RX_POWER]))
        else $error("receiver settings not applied on arrival");
    wake_flag_a: assert property (
        tx_wake || rx_wake |=> wake_flag_reg)
        else $error("wake flag missed a wake event");
    tick_pulse_a: assert property (
        tick_reg |=> !tick_reg)
        else $error("tick held for more than one cycle");
    pin_gate_a: assert property (
        rx_wake_src_reg[BIT_SLEEP_WAKE] |-> !rx_pin_wake)
        else $error("pin wake active while sleep timer wake selected");

    // The start of a transfer is one request pulse with busy status.
    sequence xfer_request;
        xfer_go;
    endsequence

    sequence xfer_pending;
        rx_xfer_req && rx_xfer_reg == XFER_BUSY ##1 !rx_xfer_req;
    endsequence

    xfer_start_a: assert property (
        xfer_request |=> xfer_pending)
        else $error("transfer start not signalled as one pulse");
    power_hold_a: assert property (
        !rx_settings_arrived |=> $stable(rx_power_applied_reg))
        else $error("receiver power bit changed without settings");
    tx_pin_wake_a: assert property (
        tx_powered_down && tx_pin_wake |=> !tx_powered_down)
        else $error("enabled transmitter pin change did not wake");
    rx_pin_wake_a: assert property (
        rx_powered_down && rx_pin_wake |=> !rx_powered_down)
        else $error("enabled receiver pin change did not wake");
    flag_clear_a: assert property (
        wr_int && reg_wdata[BIT_WAKE_FLAG] && !tx_wake && !rx_wake
        |=> !wake_flag_reg)
        else $error("wake flag not cleared by a write of one");
    tick_wrap_a: assert property (
        tick_reg |-> $past(tick_cnt_reg) == TICK_W'(TICK_LEN - 1))
        else $error("tick pulse off its divider count");

endmodule

// ===== dv/pdw_link_model.sv
// Link-side model that delivers receiver settings some cycles after a request.
`timescale 1ns/100ps
module pdw_link_model #(
    parameter int DELAY = 8
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic rx_xfer_req,
    output logic      rx_settings_arrived
);
    // A fixed air delay; a slower radio only stretches the busy spell.
    int cnt_reg;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cnt_reg             <= 0;
            rx_settings_arrived <= 1'b0;
        end else begin
            rx_settings_arrived <= (cnt_reg == 1);
            if (rx_xfer_req) begin
                cnt_reg <= DELAY;
            end else if (cnt_reg > 0) begin
                cnt_reg <= cnt_reg - 1;
            end
        end
    end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the power-down and wake-up controller.
`timescale 1ns/100ps
module tb_top;
    import pdw_pkg::*;
    localparam int T = 20;
    localparam int F = 4;
    localparam logic [7:0] ADR [14] = '{OFS_RX_WAKE_SRC, OFS_RX_SLEEP_LO,
        OFS_RX_SLEEP_HI, OFS_RX_WAKE_CNT, OFS_RX_WAKE_EXT, OFS_TX_WAKE_EXT,
        OFS_TX_SLEEP_LO, OFS_TX_SLEEP_HI, OFS_TX_WAKE_CNT, OFS_TX_MODE,
        OFS_RX_MODE, OFS_RX_XFER, OFS_INT_STATUS, 8'h10};
    localparam logic [7:0] RV [14] = '{RST_RX_WAKE_SRC, RST_TIMER, RST_TIMER,
        RST_TIMER, RST_TIMER, RST_TIMER, RST_TIMER, RST_TIMER, RST_TIMER,
        RST_TX_MODE, RST_RX_MODE, XFER_IDLE, 8'h00, 8'h00};
    logic       ref_clk, reset_n, reg_wr, reg_rd, direct_input_bit1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [3:0] general_inputs;
    logic       tx_link_up, rx_link_up, rx_settings_arrived, rx_xfer_req;
    logic       tx_powered_down, rx_powered_down;
    int         n_errors, n_tests, n;

    pdw_top #(.TICK_LEN(T), .FILTER_LEN(F)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .direct_input_bit1(direct_input_bit1),
        .general_inputs(general_inputs), .tx_link_up(tx_link_up),
        .rx_link_up(rx_link_up), .rx_settings_arrived(rx_settings_arrived),
        .rx_xfer_req(rx_xfer_req), .tx_powered_down(tx_powered_down),
        .rx_powered_down(rx_powered_down));
    pdw_link_model #(.DELAY(8)) link (
        .ref_clk(ref_clk), .reset_n(reset_n), .rx_xfer_req(rx_xfer_req),
        .rx_settings_arrived(rx_settings_arrived));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rng(input string nm, input int v, input int lo,
                       input int hi);
        chk(nm, 8'(v >= lo && v <= hi), 8'h01);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    // Polls one side's power state so the measured span can be judged.
    task automatic wait_for(input bit rx, input logic lvl, input int mx,
                            output int k);
        k = 0;
        while (((rx ? rx_powered_down : tx_powered_down) !== lvl) && k < mx)
        begin
            @(posedge ref_clk);
            #1;
            k++;
        end
    endtask
    task automatic rst();
        @(posedge ref_clk);
        reset_n           <= 1'b0;
        tx_link_up        <= 1'b1;
        rx_link_up        <= 1'b1;
        direct_input_bit1 <= 1'b0;
        general_inputs    <= 4'h0;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        #1;
    endtask
    task automatic endt(input string nm);
        $display("[DONE] %s", nm);
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {direct_input_bit1, general_inputs} = '0;
        {tx_link_up, rx_link_up, reset_n} = 3'b110;
        n_errors = 0;
        n_tests = 0;
        rst();
        foreach (ADR[i]) begin
            rd(ADR[i], d);
            chk("reset value", d, RV[i]);
        end
        for (int i = 0; i < 9; i++) begin
            wr(ADR[i], 8'ha5);
            rd(ADR[i], d);
            chk("write back", d, (i == 0) ? 8'h25 : 8'ha5);
        end
        endt("registers");
        // Transmitter without a link: forced entry, sleep, windows, relink.
        rst();
        @(posedge ref_clk) tx_link_up <= 1'b0;
        wr(OFS_TX_SLEEP_LO, 8'h03);
        wr(OFS_TX_MODE, 8'h00);
        wait_for(0, 1, 5, n);
        chk("zero wake count", tx_powered_down, 1'b0);
        wr(OFS_TX_WAKE_CNT, 8'h02);
        wait_for(0, 1, 5, n);
        rng("forced entry", n, 0, 4);
        wait_for(0, 0, 4 * T, n);
        rng("sleep span", n, 2 * T, 3 * T + 3);
        rd(OFS_INT_STATUS, d);
        chk("wake flag", d & 8'h02, 8'h02);
        wr(OFS_INT_STATUS, 8'h02);
        rd(OFS_INT_STATUS, d);
        chk("wake flag clear", d & 8'h02, 8'h00);
        wait_for(0, 1, 3 * T, n);
        rng("wake window", n, T - 10, 2 * T + 3);
        wait_for(0, 0, 4 * T, n);
        wr(OFS_TX_MODE, 8'h40);
        wait_for(0, 1, 3 * T, n);
        rng("no link sleep", n, T - 4, 2 * T + 3);
        wait_for(0, 0, 4 * T, n);
        @(posedge ref_clk) tx_link_up <= 1'b1;
        wait_for(0, 1, 6 * T, n);
        chk("stays awake", tx_powered_down, 1'b0);
        endt("transmitter timers");
        rst();
        wr(OFS_TX_WAKE_CNT, 8'h02);
        wr(OFS_TX_WAKE_EXT, 8'h02);
        @(posedge ref_clk) {tx_link_up, rx_link_up} <= 2'b00;
        wait_for(0, 1, 7 * T, n);
        rng("auto entry", n, 5 * T, 6 * T + 3);
        chk("auto off", rx_powered_down, 1'b0);
        endt("automatic entry");
        rst();
        wr(OFS_TX_WAKE_CNT, 8'h03);
        wr(OFS_TX_WAKE_EXT, 8'h01);
        wr(OFS_TX_MODE, 8'h20);
        wait_for(0, 1, 5, n);
        @(posedge ref_clk) direct_input_bit1 <= 1'b1;
        repeat (F - 2) @(posedge ref_clk);
        direct_input_bit1 <= 1'b0;
        wait_for(0, 0, 3 * F, n);
        chk("short pulse", tx_powered_down, 1'b1);
        @(posedge ref_clk) direct_input_bit1 <= 1'b1;
        wait_for(0, 0, 3 * F, n);
        rng("pin wake", n, F, F + 4);
        wait_for(0, 1, 7 * T, n);
        rng("pin window", n, 5 * T, 6 * T + 3);
        wr(OFS_TX_MODE, 8'h00);
        @(posedge ref_clk) direct_input_bit1 <= 1'b0;
        wait_for(0, 0, 3 * F, n);
        chk("pin wake off", tx_powered_down, 1'b1);
        endt("transmitter pin wake");
        rst();
        wr(OFS_RX_WAKE_CNT, 8'h02);
        wr(OFS_RX_SLEEP_LO, 8'h02);
        wr(OFS_RX_MODE, 8'h00);
        wait_for(1, 1, 5, n);
        chk("held for transfer", rx_powered_down, 1'b0);
        wr(OFS_RX_XFER, 8'h01);
        chk("transfer request", rx_xfer_req, 1'b1);
        wr(OFS_RX_XFER, 8'h01);
        chk("busy refused", rx_xfer_req, 1'b0);
        rd(OFS_RX_XFER, d);
        chk("transfer busy", d, XFER_BUSY);
        wait_for(1, 1, 20, n);
        chk("rx entry", rx_powered_down, 1'b1);
        rd(OFS_RX_XFER, d);
        chk("transfer idle", d, XFER_IDLE);
        wait_for(1, 0, 4 * T, n);
        chk("timer ignored", rx_powered_down, 1'b1);
        @(posedge ref_clk) general_inputs <= 4'h2;
        wait_for(1, 0, 3 * F, n);
        chk("masked pin", rx_powered_down, 1'b1);
        @(posedge ref_clk) general_inputs <= 4'ha;
        wait_for(1, 0, 3 * F, n);
        rng("rx pin wake", n, F, F + 4);
        wr(OFS_RX_WAKE_SRC, 8'h18);
        wait_for(1, 1, 3 * T, n);
        chk("rx window", rx_powered_down, 1'b1);
        @(posedge ref_clk) general_inputs <= 4'h2;
        wait_for(1, 0, F + 6, n);
        chk("timer priority", rx_powered_down, 1'b1);
        wait_for(1, 0, 3 * T, n);
        chk("rx timer wake", rx_powered_down, 1'b0);
        endt("receiver");
        print_verdict();
    end
endmodule
